// >>> wdtr_pkg.sv
/*
  Shared constants and types for the watchdog with timebase reset:
  register map, field positions, timing counts, bus request struct
  and the mode enumeration.
  Assumes a 100 MHz system clock and a 32.768 kHz crystal time base.
*/
package wdtr_pkg;

  // System clock and crystal time base
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned OSC_FREQ_HZ     = 32768;
  localparam int unsigned OSC_TICK_CYCLES =
    1000000000 / (CLK_PERIOD_NS * OSC_FREQ_HZ);
  localparam int unsigned OSC_CNT_W       = 12;

  // The 1 Hz signal toggles every half second of crystal ticks
  localparam int unsigned TB_HALF_TICKS   = OSC_FREQ_HZ / 2;
  localparam int unsigned TB_CNT_W        = 16;

  // Least unattended time before the CPU is reset, in seconds
  localparam int unsigned WD_TIMEOUT_S    = 3;
  localparam logic [1:0]  WD_CNT_RESET    = 2'h0;
  localparam logic [1:0]  WD_CNT_MAX      = 2'h3;

  // Length of the internal initial reset pulse, in system clocks
  localparam logic [2:0]  INIT_RST_CYCLES = 3'h4;

  // Register port
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 4;
  localparam logic [7:0]  RESTART_ADDR    = 8'hD4;
  localparam logic [7:0]  STATUS_ADDR     = 8'hD5;
  localparam logic [3:0]  RDATA_RESET     = 4'h0;

  // Restart register fields
  localparam int unsigned WD_RESTART_BIT  = 1;
  localparam int unsigned TB_RESTART_BIT  = 0;

  // Status register fields
  localparam int unsigned ST_CNT_LSB      = 0;
  localparam int unsigned ST_HZ1_BIT      = 2;
  localparam int unsigned ST_SLEEP_BIT    = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } wdtr_req_s;

  typedef enum logic [1:0] {
    MODE_CLK_WAIT,
    MODE_RUN,
    MODE_SLEEP,
    MODE_INIT_RST
  } wdtr_mode_e;

endpackage

// >>> wdtr_osc.sv
/*
  Crystal oscillator model: a free running divider of the system clock
  that gives one pulse per crystal period.
  Assumes only the chip reset touches it; sleep never stops it.
*/
`timescale 1ns/1ns
module wdtr_osc (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  output logic      osc_tick_o
);

  logic [wdtr_pkg::OSC_CNT_W-1:0] cnt_r;
  logic                           wrap;

  assign wrap = (cnt_r ==
    wdtr_pkg::OSC_CNT_W'(wdtr_pkg::OSC_TICK_CYCLES - 1));

  // No enable input: it runs from power-up without software help
  always_ff @(posedge clock_i) begin // R13
    if (!reset_n_i) begin
      cnt_r      <= '0;
      osc_tick_o <= 1'b0;
    end else begin
      cnt_r      <= wrap ? '0 : cnt_r + 1'b1;
      osc_tick_o <= wrap;
    end
  end

endmodule

// >>> wdtr_timebase.sv
/*
  Clock timer prescaler: divides crystal ticks into the 1 Hz level and
  a one-cycle pulse on its rising edge.
  Assumes run_i gates its clock and clr_i restarts it from low.
*/
`timescale 1ns/1ns
module wdtr_timebase #(
  parameter int unsigned HALF_TICKS = wdtr_pkg::TB_HALF_TICKS
) (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic clr_i,
  input  wire logic run_i,
  input  wire logic osc_tick_i,
  output logic      hz1_o,
  output logic      rise_o
);

  logic [wdtr_pkg::TB_CNT_W-1:0] cnt_r;
  logic                          half;

  assign half = osc_tick_i && run_i &&
    (cnt_r == wdtr_pkg::TB_CNT_W'(HALF_TICKS - 1));

  always_ff @(posedge clock_i) begin
    if (!reset_n_i || clr_i) begin
      cnt_r  <= '0;
      hz1_o  <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      if (osc_tick_i && run_i) begin // R7
        cnt_r <= half ? '0 : cnt_r + 1'b1;
      end
      if (half) begin
        hz1_o <= !hz1_o;
      end
      rise_o <= half && !hz1_o;
    end
  end

endmodule

// >>> wdtr_top.sv
/*
  Watchdog with timebase reset: a two-bit counter on the 1 Hz clock
  timer tick that resets the CPU when software stops restarting it,
  with sleep handling and CPU clock hold-off after reset.
  Assumes a single 100 MHz clock, a register port whose read data is
  due in the cycle after the read strobe, and one-cycle pulses for the
  sleep instruction and the sleep wake-up event.
*/
`timescale 1ns/1ns

// How it works
// R1: Two-bit counter advances on 1 Hz tick
// R2: Counter overflow raises internal CPU initial reset
// R3: No restart for three seconds resets CPU
// R4: Counting continues in halt; reset in 3-4s
// R5: Sleep instruction clears watchdog and clock timer
// R6: After sleep both resume as after reset
// R7: Sleep gates timer clock; oscillator keeps running
// R8: Writing restart bit one clears watchdog counter
// R9: Combined bit clears clock timer and watchdog
// R10: Zero writes do nothing; bits read zero
// R11: CPU clock withheld until first 1 Hz high
// R12: Software restarts watchdog within three seconds
// R13: Oscillator runs from power-up, no software
// R14: Restart clears counter on capturing edge
module wdtr_top #(
  parameter int unsigned TB_HALF_TICKS = wdtr_pkg::TB_HALF_TICKS
) (
  input  wire logic                 clock_i,
  input  wire logic                 reset_n_i,
  input  wire wdtr_pkg::wdtr_req_s  bus_req_i,
  input  wire logic                 sleep_instruction_i,
  input  wire logic                 sleep_wake_i,
  output logic [3:0]                rd_data_o,
  output logic                      cpu_init_reset_o,
  output logic                      cpu_clk_en_o,
  output logic                      hz1_o,
  output logic [1:0]                wd_count_o
);

  wdtr_pkg::wdtr_mode_e mode_r;
  wdtr_pkg::wdtr_mode_e mode_nxt;

  logic       osc_tick;
  logic       tb_rise;
  logic       tb_run;
  logic       tb_clr;
  logic       wd_clr;
  logic       wd_count;
  logic       overflow;
  logic       hit_restart;
  logic       hit_status;
  logic       wd_restart;
  logic       tb_restart;
  logic       sleep_entry;
  logic [2:0] rst_cnt_r;

  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    addr_hit = (addr == target);
  endfunction

  // Register decode
  always_comb begin
    hit_restart = 1'b0;
    hit_status  = 1'b0;
    if (addr_hit(bus_req_i.addr, wdtr_pkg::RESTART_ADDR)) begin
      hit_restart = 1'b1;
    end else if (addr_hit(bus_req_i.addr, wdtr_pkg::STATUS_ADDR)) begin
      hit_status = 1'b1;
    end
  end

  // A zero in either bit is simply not a restart
  assign wd_restart = bus_req_i.wr && hit_restart &&
    bus_req_i.wdata[wdtr_pkg::WD_RESTART_BIT]; // R8 R10
  assign tb_restart = bus_req_i.wr && hit_restart &&
    bus_req_i.wdata[wdtr_pkg::TB_RESTART_BIT]; // R9 R10

  assign sleep_entry = (mode_r == wdtr_pkg::MODE_RUN) &&
    sleep_instruction_i;

  // Halt is not an input: the count never depends on it
  assign wd_count = tb_rise &&
    ((mode_r == wdtr_pkg::MODE_RUN) ||
     (mode_r == wdtr_pkg::MODE_CLK_WAIT)); // R4

  // A restart in the same cycle as the last tick wins over it
  assign wd_clr = wd_restart || tb_restart || sleep_entry ||
    (mode_r == wdtr_pkg::MODE_SLEEP) ||
    (mode_r == wdtr_pkg::MODE_INIT_RST); // R14 R5

  assign overflow = wd_count && !wd_clr &&
    (wd_count_o == wdtr_pkg::WD_CNT_MAX); // R2 R3

  assign tb_clr = tb_restart || sleep_entry || overflow; // R9 R5
  assign tb_run = (mode_r != wdtr_pkg::MODE_SLEEP); // R7

  wdtr_osc u_osc (
    .clock_i    (clock_i),
    .reset_n_i  (reset_n_i),
    .osc_tick_o (osc_tick)
  );

  wdtr_timebase #(
    .HALF_TICKS (TB_HALF_TICKS)
  ) u_timebase (
    .clock_i    (clock_i),
    .reset_n_i  (reset_n_i),
    .clr_i      (tb_clr),
    .run_i      (tb_run),
    .osc_tick_i (osc_tick),
    .hz1_o      (hz1_o),
    .rise_o     (tb_rise)
  );

  // Mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      wdtr_pkg::MODE_CLK_WAIT: begin
        if (overflow) begin
          mode_nxt = wdtr_pkg::MODE_INIT_RST;
        end else if (tb_rise) begin
          mode_nxt = wdtr_pkg::MODE_RUN; // R11
        end
      end
      wdtr_pkg::MODE_RUN: begin
        if (overflow) begin
          mode_nxt = wdtr_pkg::MODE_INIT_RST; // R2
        end else if (sleep_instruction_i) begin
          mode_nxt = wdtr_pkg::MODE_SLEEP; // R5
        end
      end
      wdtr_pkg::MODE_SLEEP: begin
        // Both timers restart from zero, as after reset
        if (sleep_wake_i) begin
          mode_nxt = wdtr_pkg::MODE_RUN; // R6
        end
      end
      wdtr_pkg::MODE_INIT_RST: begin
        if (rst_cnt_r == 3'h1) begin
          mode_nxt = wdtr_pkg::MODE_CLK_WAIT; // R11
        end
      end
      default: begin
        mode_nxt = wdtr_pkg::MODE_CLK_WAIT;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      mode_r <= wdtr_pkg::MODE_CLK_WAIT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Watchdog counter
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      wd_count_o <= wdtr_pkg::WD_CNT_RESET;
    end else if (wd_clr) begin
      wd_count_o <= wdtr_pkg::WD_CNT_RESET; // R8 R9 R14
    end else if (wd_count) begin
      wd_count_o <= wd_count_o + 2'h1; // R1
    end
  end

  // Internal initial reset pulse; no pin is involved
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rst_cnt_r        <= 3'h0;
      cpu_init_reset_o <= 1'b0;
    end else if (overflow) begin
      rst_cnt_r        <= wdtr_pkg::INIT_RST_CYCLES; // R2 R3
      cpu_init_reset_o <= 1'b1;
    end else if (rst_cnt_r != 3'h0) begin
      rst_cnt_r        <= rst_cnt_r - 3'h1;
      cpu_init_reset_o <= (rst_cnt_r != 3'h1);
    end
  end

  // CPU clock hold-off until the 1 Hz level first goes high
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cpu_clk_en_o <= 1'b0;
    end else if (overflow) begin
      cpu_clk_en_o <= 1'b0;
    end else if ((mode_r == wdtr_pkg::MODE_CLK_WAIT) && tb_rise) begin
      cpu_clk_en_o <= 1'b1; // R11
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rd_data_o <= wdtr_pkg::RDATA_RESET;
    end else if (bus_req_i.rd && hit_status) begin
      rd_data_o <= '0;
      rd_data_o[wdtr_pkg::ST_CNT_LSB +: 2] <= wd_count_o;
      rd_data_o[wdtr_pkg::ST_HZ1_BIT]      <= hz1_o;
      rd_data_o[wdtr_pkg::ST_SLEEP_BIT]    <=
        (mode_r == wdtr_pkg::MODE_SLEEP);
    end else begin
      rd_data_o <= wdtr_pkg::RDATA_RESET; // R10
    end
  end

  a_wd_cnt_step: // R1
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      wd_count && !wd_clr && !overflow
      |=> wd_count_o == $past(wd_count_o) + 2'h1)
    else $error("watchdog count did not advance on tick");

  a_overflow_reset: // R2
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      overflow |=> cpu_init_reset_o && !cpu_clk_en_o)
    else $error("overflow did not raise cpu reset");

  a_reset_length: // R3
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(cpu_init_reset_o) |-> cpu_init_reset_o[*4]
      ##1 !cpu_init_reset_o)
    else $error("cpu reset pulse has wrong length");

  a_overflow_cause: // R3
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(cpu_init_reset_o) |->
      $past(wd_count_o) == 2'h3 && $past(tb_rise))
    else $error("cpu reset without counter overflow");

  a_wd_restart_clr: // R8
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      wd_restart |=> wd_count_o == 2'h0 && !cpu_init_reset_o)
    else $error("watchdog restart did not clear counter");

  a_tb_restart_clr: // R9
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      tb_restart |=> wd_count_o == 2'h0 && !hz1_o && !tb_rise)
    else $error("combined restart did not clear timers");

  a_zero_write_noop: // R10
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      bus_req_i.wr && hit_restart && bus_req_i.wdata[1:0] == 2'h0
      && !wd_count && mode_r == wdtr_pkg::MODE_RUN
      && !sleep_instruction_i
      |=> $stable(wd_count_o))
    else $error("zero write changed the watchdog");

  a_restart_reads_zero: // R10
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      bus_req_i.rd && hit_restart |=> rd_data_o == 4'h0)
    else $error("restart register read nonzero");

  a_sleep_clears: // R5
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      sleep_entry |=> wd_count_o == 2'h0 && !hz1_o
      && mode_r == wdtr_pkg::MODE_SLEEP)
    else $error("sleep entry did not clear timers");

  a_sleep_gated: // R7
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      mode_r == wdtr_pkg::MODE_SLEEP
      && $past(mode_r) == wdtr_pkg::MODE_SLEEP
      |-> $stable(hz1_o) && !tb_rise)
    else $error("clock timer ran during sleep");

  a_clk_after_hz1: // R11
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(cpu_clk_en_o) |-> $past(tb_rise) && hz1_o)
    else $error("cpu clock enabled before 1 Hz high");

  // Stale status data would look like a live watchdog value
  a_rdata_idle: // R10
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !$past(bus_req_i.rd && hit_status) |-> rd_data_o == 4'h0)
    else $error("read data nonzero outside a status read");

  a_wait_no_clk: // R11
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      mode_r == wdtr_pkg::MODE_CLK_WAIT |-> !cpu_clk_en_o)
    else $error("cpu clock running during hold-off");

  a_reset_no_clk: // R11
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      mode_r == wdtr_pkg::MODE_INIT_RST |-> !cpu_clk_en_o)
    else $error("cpu clock running during internal reset");

  a_pulse_ends_wait: // R11
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $fell(cpu_init_reset_o) |-> mode_r == wdtr_pkg::MODE_CLK_WAIT)
    else $error("internal reset ended outside hold-off");

  a_count_hold: // R1
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !wd_count && !wd_clr |=> $stable(wd_count_o))
    else $error("watchdog count moved without a tick");

  a_overflow_clears: // R2
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      overflow |=> wd_count_o == wdtr_pkg::WD_CNT_RESET && !hz1_o)
    else $error("overflow did not clear the timers");

  a_sleep_held_clear: // R5
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      mode_r == wdtr_pkg::MODE_SLEEP
      |-> wd_count_o == wdtr_pkg::WD_CNT_RESET && !cpu_init_reset_o)
    else $error("watchdog not held cleared in sleep");

  a_sleep_only_run: // R5
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      sleep_instruction_i && (mode_r == wdtr_pkg::MODE_CLK_WAIT
      || mode_r == wdtr_pkg::MODE_INIT_RST)
      |=> mode_r != wdtr_pkg::MODE_SLEEP)
    else $error("sleep entered outside run mode");

  a_wake_resume: // R6
    assert property (@(posedge clock_i) disable iff (!reset_n_i)
      mode_r == wdtr_pkg::MODE_SLEEP && sleep_wake_i
      |=> mode_r == wdtr_pkg::MODE_RUN
      && wd_count_o == wdtr_pkg::WD_CNT_RESET && !hz1_o)
    else $error("wake did not resume from cleared timers");

  c_tb_restart_high:
    cover property (@(posedge clock_i) disable iff (!reset_n_i)
      tb_restart && hz1_o);

  c_overflow_reset:
    cover property (@(posedge clock_i) disable iff (!reset_n_i)
      overflow ##1 cpu_init_reset_o);

  c_sleep_wake:
    cover property (@(posedge clock_i) disable iff (!reset_n_i)
      sleep_entry ##[1:20] (mode_r == wdtr_pkg::MODE_RUN));

  c_restart_late:
    cover property (@(posedge clock_i) disable iff (!reset_n_i)
      wd_restart && wd_count_o == 2'h3);

  c_clk_release:
    cover property (@(posedge clock_i) disable iff (!reset_n_i)
      $rose(cpu_clk_en_o));

endmodule

// >>> wdtr_sw_model.sv
/*
  Software model: restarts the watchdog over the register port at a
  fixed interval.
  Assumes the bench routes its requests to the design only while
  enable_i is high.
*/
`timescale 1ns/1ns
module wdtr_sw_model #(
  parameter int unsigned KICK_CYCLES = 1000
) (
  input  wire logic           clock_i,
  input  wire logic           reset_n_i,
  input  wire logic           enable_i,
  output wdtr_pkg::wdtr_req_s req_o
);
  int unsigned cnt_r;

  // Interval kept well below three timer periods
  always_ff @(posedge clock_i) begin
    req_o <= '0;
    if (!reset_n_i || !enable_i) begin
      cnt_r <= 0;
    end else if (cnt_r == KICK_CYCLES - 1) begin
      cnt_r <= 0;
      req_o.addr <= wdtr_pkg::RESTART_ADDR;
      req_o.wdata <= 4'h2;
      req_o.wr <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule

// >>> wdtr_top_test.sv
/*
  Self-checking bench for the watchdog with timebase reset.
  Assumes the crystal divider gives one tick every 3051 clocks and a
  shortened 1 Hz half period of one crystal tick.
*/
`timescale 1ns/1ns
module wdtr_top_test;
  localparam int HALF = 1;
  localparam int XT   = 3051;
  localparam int P    = 2 * HALF * XT;
  logic                clock_i;
  logic                reset_n_i;
  logic                sleep_i;
  logic                wake_i;
  logic                sw_en;
  logic                seen;
  logic [3:0]          rd_data;
  logic                init_rst;
  logic                clk_en;
  logic                hz1;
  logic [1:0]          count;
  wdtr_pkg::wdtr_req_s tb_req;
  wdtr_pkg::wdtr_req_s sw_req;
  wdtr_pkg::wdtr_req_s bus_req;
  int                  fails;
  int                  checked;
  int                  cyc;
  int                  n;

  assign bus_req = sw_en ? sw_req : tb_req;

  wdtr_top #(.TB_HALF_TICKS(HALF)) u_wdtr_top (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req),
    .sleep_instruction_i(sleep_i), .sleep_wake_i(wake_i),
    .rd_data_o(rd_data), .cpu_init_reset_o(init_rst),
    .cpu_clk_en_o(clk_en), .hz1_o(hz1), .wd_count_o(count));

  wdtr_sw_model #(.KICK_CYCLES(2 * P)) u_wdtr_sw_model (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(sw_en),
    .req_o(sw_req));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clock_i);
    tb_req.addr <= a;
    tb_req.wdata <= d;
    tb_req.wr <= 1'b1;
    @(posedge clock_i);
    tb_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    @(posedge clock_i);
    tb_req.addr <= a;
    tb_req.rd <= 1'b1;
    @(posedge clock_i);
    tb_req.rd <= 1'b0;
    #1;
    chk(rd_data, e);
  endtask

  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask

  // Waits out the high half, then the next rise of the 1 Hz level
  task automatic next_rise();
    for (n = 0; n < P && hz1 !== 1'b0; n++) tick();
    for (n = 0; n < P && hz1 !== 1'b1; n++) tick();
    repeat (2) tick();
  endtask

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    reset_n_i = 1'b0;
    sleep_i = 1'b0;
    wake_i = 1'b0;
    sw_en = 1'b0;
    tb_req = '0;
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    tick();
    chk(count, 0);
    chk(clk_en, 0);
    rd(8'hD4, 4'h0);
    rd(8'h10, 4'h0);
    $display("test reset done");
    for (n = 0; n < P && clk_en !== 1'b1; n++) tick();
    chk(hz1, 1);
    chk(count, 1);
    $display("test clock hold-off done");
    wr(8'hD4, 4'h0);
    chk(count, 1);
    wr(8'hD5, 4'hF);
    rd(8'hD5, 4'h5);
    wr(8'hD4, 4'h2);
    chk(count, 0);
    chk(hz1, 1);
    next_rise();
    chk(count, 1);
    wr(8'hD4, 4'h1);
    chk(count, 0);
    chk(hz1, 0);
    rd(8'hD4, 4'h0);
    for (n = 0; n < HALF * XT + 10 && hz1 !== 1'b1; n++) tick();
    repeat (2) tick();
    chk(count, 1);
    $display("test restart bits done");
    @(posedge clock_i);
    sleep_i <= 1'b1;
    @(posedge clock_i);
    sleep_i <= 1'b0;
    tick();
    chk({hz1, count}, 0);
    rd(8'hD5, 4'h8);
    repeat (2 * XT) tick();
    chk({hz1, count}, 0);
    @(posedge clock_i);
    wake_i <= 1'b1;
    @(posedge clock_i);
    wake_i <= 1'b0;
    rd(8'hD5, 4'h0);
    for (n = 0; n < HALF * XT + 10 && hz1 !== 1'b1; n++) tick();
    repeat (2) tick();
    chk(count, 1);
    $display("test sleep done");
    @(posedge clock_i);
    sw_en <= 1'b1;
    seen = 1'b0;
    repeat (5 * P) begin
      tick();
      if (init_rst === 1'b1) seen = 1'b1;
    end
    chk(seen, 0);
    @(posedge clock_i);
    sw_en <= 1'b0;
    $display("test kept alive done");
    wr(8'hD4, 4'h1);
    for (n = 0; n < 4 * P + 10 && init_rst !== 1'b1; n++) tick();
    chk(n >= 3 * P && n <= 4 * P, 1);
    chk({clk_en, count}, 0);
    repeat (3) tick();
    chk(init_rst, 1);
    tick();
    chk(init_rst, 0);
    for (n = 0; n < P && clk_en !== 1'b1; n++) tick();
    chk(hz1, 1);
    $display("test timeout done");
    conclude();
  end
endmodule
